// ==== gcs_global_regs.v ====
`timescale 1ns/1ps
`include "gcs_consts.vh"
// Contract
// R1 - Config bit 12 selects irq pin drive
// R2 - Config bit 13 selects compare pin drive
// R3 - Bit 14 selects hysteresis 1/16 or 1/32
// R4 - Bit 15 lets halt input stop sequencer
// R5 - Bit 16 takes coil currents from target
// R6 - Direct mode scales coils by hold current
// R7 - Direct mode disables velocity current regulation
// R8 - Bit 17 routes test signal to decoder
// R9 - Host keeps test bit zero normally
// R10 - Reset flag set after any reset
// R11 - Reset returns all registers to defaults
// R12 - Fault flag set on driver shutdown
// R13 - Read clears fault only when conditions gone
// R14 - Pump undervolt flag set, driver disabled
// R15 - Flags register is read to clear
// R16 - Count each successful uart write
// R17 - Reads keep count; no counting in SPI
// R18 - Counter wraps 255 to zero
// R19 - Counter cleared by device reset
module gcs_global_regs (
  input  wire        REF_CLK_I,
  input  wire        RST_N_I,
  input  wire [6:0]  REG_ADDR_I,
  input  wire        REG_WR_I,
  input  wire [31:0] REG_WDATA_I,
  input  wire        REG_RD_I,
  output reg  [31:0] REG_RDATA_O,
  input  wire        REG_UART_MODE_I,
  input  wire        DRV_OVERTEMP_I,
  input  wire        DRV_SHORT_I,
  input  wire        PUMP_UNDERVOLT_I,
  input  wire        IRQ_ACTIVE_I,
  input  wire        COMPARE_ACTIVE_I,
  input  wire        HALT_INPUT_PIN_I,
  input  wire [31:0] FREQ_REF_I,
  input  wire [31:0] FREQ_ACT_I,
  input  wire [8:0]  SEQ_COIL_A_I,
  input  wire [8:0]  SEQ_COIL_B_I,
  input  wire        QUIET_REG_EN_I,
  input  wire [2:0]  TEST_SIG_I,
  input  wire        DECODER_OUT_I,
  output wire        IRQ_DIAG_PIN_O,
  output wire        IRQ_DIAG_PIN_OE_O,
  output wire        COMPARE_DIAG_PIN_O,
  output wire        COMPARE_DIAG_PIN_OE_O,
  output wire        FREQ_ABOVE_O,
  output wire        FREQ_BELOW_O,
  output wire        SEQ_STOP_O,
  output wire [8:0]  COIL_A_O,
  output wire [8:0]  COIL_B_O,
  output wire        QUIET_REG_EN_O,
  output wire        DRIVER_ENABLE_O,
  output wire        DECODER_OUT_PIN_O,
  output wire        TEST_ANALOG_EN_O,
  output wire [1:0]  TEST_SELECT_O
);
  reg  [17:0] config_q;
  reg  [2:0]  flags_q;
  reg  [7:0]  wrcnt_q;
  reg  [31:0] target_q;
  reg  [4:0]  hold_q;
  wire        drv_fault = DRV_OVERTEMP_I | DRV_SHORT_I;
  wire        flags_rd  = REG_RD_I & (REG_ADDR_I == `GCS_OFS_FLAGS);
  wire [8:0]  coil_a_scaled;
  wire [8:0]  coil_b_scaled;
  wire        direct    = config_q[`GCS_BIT_DIRECT];
  wire        test      = config_q[`GCS_BIT_TEST];

  function wr_hit;
    input [6:0] addr;
    input [6:0] ofs;
    begin
      wr_hit = REG_WR_I & (addr == ofs);
    end
  endfunction

  // R11 reset defaults
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      config_q <= `GCS_CONFIG_RST;
      target_q <= `GCS_TARGET_RST;
      hold_q   <= `GCS_HOLD_RST;
    end else begin
      if (wr_hit(REG_ADDR_I, `GCS_OFS_CONFIG)) begin
        config_q <= REG_WDATA_I[17:0];
      end
      if (wr_hit(REG_ADDR_I, `GCS_OFS_TARGET)) begin
        target_q <= REG_WDATA_I;
      end
      if (wr_hit(REG_ADDR_I, `GCS_OFS_HOLD)) begin
        hold_q <= REG_WDATA_I[4:0];
      end
    end
  end

  // R10 reset flag, R12 R14 set wins over read clear
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flags_q <= `GCS_FLAGS_RST;
    end else begin
      // R15 read clears flags
      if (flags_rd) begin
        flags_q[`GCS_FLAG_RESET] <= 1'b0;
        // R13 fault clears only if conditions gone
        flags_q[`GCS_FLAG_DRV_ERR] <= drv_fault;
        flags_q[`GCS_FLAG_PUMP_UV] <= PUMP_UNDERVOLT_I;
      end else begin
        // R12 fault sets flag
        if (drv_fault) begin
          flags_q[`GCS_FLAG_DRV_ERR] <= 1'b1;
        end
        // R14 undervolt sets flag
        if (PUMP_UNDERVOLT_I) begin
          flags_q[`GCS_FLAG_PUMP_UV] <= 1'b1;
        end
      end
    end
  end

  // R19 counter cleared at reset
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wrcnt_q <= `GCS_WRCNT_RST;
    end else if (REG_WR_I && REG_UART_MODE_I) begin
      // R16 R17 R18 uart writes only, wraps
      wrcnt_q <= wrcnt_q + 8'h01;
    end
  end

  // Read data registered; reads of the counter have no side effect
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 32'h00000000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `GCS_OFS_CONFIG: REG_RDATA_O <= {14'h0000, config_q};
        `GCS_OFS_FLAGS:  REG_RDATA_O <= {29'h00000000, flags_q};
        `GCS_OFS_WRCNT:  REG_RDATA_O <= {24'h000000, wrcnt_q};
        default:         REG_RDATA_O <= 32'h00000000;
      endcase
    end
  end

  // R1 irq pin drive style
  assign IRQ_DIAG_PIN_O    = config_q[`GCS_BIT_IRQ_PP] ? IRQ_ACTIVE_I : 1'b0;
  assign IRQ_DIAG_PIN_OE_O = config_q[`GCS_BIT_IRQ_PP] ? 1'b1 : IRQ_ACTIVE_I;
  // R2 compare pin drive style
  assign COMPARE_DIAG_PIN_O    = config_q[`GCS_BIT_CMP_PP] ? COMPARE_ACTIVE_I : 1'b0;
  assign COMPARE_DIAG_PIN_OE_O = config_q[`GCS_BIT_CMP_PP] ? 1'b1 : COMPARE_ACTIVE_I;

  // R3 hysteresis band select
  wire [31:0] hys = config_q[`GCS_BIT_SMALL_HYS] ? (FREQ_REF_I >> `GCS_HYS_SHIFT_SML)
                                                 : (FREQ_REF_I >> `GCS_HYS_SHIFT_BIG);
  assign FREQ_ABOVE_O = ({1'b0, FREQ_ACT_I} > ({1'b0, FREQ_REF_I} + {1'b0, hys}));
  assign FREQ_BELOW_O = ({1'b0, FREQ_ACT_I} + {1'b0, hys}) < {1'b0, FREQ_REF_I};

  // R4 emergency halt
  assign SEQ_STOP_O = config_q[`GCS_BIT_STOP_EN] & HALT_INPUT_PIN_I;

  // R6 scale by hold current
  gcs_coil_scale u_scale_a (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .coil_i  (target_q[8:0]),
    .hold_i  (hold_q),
    .coil_o  (coil_a_scaled)
  );
  gcs_coil_scale u_scale_b (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .coil_i  (target_q[24:16]),
    .hold_i  (hold_q),
    .coil_o  (coil_b_scaled)
  );

  // R5 direct coil source
  assign COIL_A_O = direct ? coil_a_scaled : SEQ_COIL_A_I;
  assign COIL_B_O = direct ? coil_b_scaled : SEQ_COIL_B_I;
  // R7 no velocity regulation
  assign QUIET_REG_EN_O = QUIET_REG_EN_I & ~direct;
  // R14 driver off in undervolt
  assign DRIVER_ENABLE_O = ~PUMP_UNDERVOLT_I & ~drv_fault;

  // R8 analog test routing; R9 leaves the bit zero in normal use
  assign TEST_ANALOG_EN_O  = test;
  assign TEST_SELECT_O     = hold_q[1:0];
  assign DECODER_OUT_PIN_O = test ? TEST_SIG_I[hold_q[1:0] == 2'h3 ? 2'h2 : hold_q[1:0]]
                                  : DECODER_OUT_I;
endmodule // gcs_global_regs

// ==== gcs_consts.vh ====
`ifndef GCS_CONSTS_VH
`define GCS_CONSTS_VH
`define GCS_ADDR_W        7
`define GCS_OFS_CONFIG    7'h00
`define GCS_OFS_FLAGS     7'h01
`define GCS_OFS_WRCNT     7'h02
`define GCS_OFS_TARGET    7'h2d
`define GCS_OFS_HOLD      7'h10
`define GCS_CONFIG_W      18
`define GCS_CONFIG_RST    18'h00000
`define GCS_BIT_IRQ_PP    12
`define GCS_BIT_CMP_PP    13
`define GCS_BIT_SMALL_HYS 14
`define GCS_BIT_STOP_EN   15
`define GCS_BIT_DIRECT    16
`define GCS_BIT_TEST      17
`define GCS_FLAG_RESET    0
`define GCS_FLAG_DRV_ERR  1
`define GCS_FLAG_PUMP_UV  2
`define GCS_FLAGS_RST     3'h1
`define GCS_WRCNT_RST     8'h00
`define GCS_TARGET_RST    32'h00000000
`define GCS_HOLD_RST      5'h00
`define GCS_HYS_SHIFT_BIG 4
`define GCS_HYS_SHIFT_SML 5
`endif

// ==== gcs_coil_scale.v ====
`timescale 1ns/1ps
`include "gcs_consts.vh"
// Scales a signed 9-bit coil value by hold current (0..31) as (v*(h+1))/32
module gcs_coil_scale (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire [8:0] coil_i,
  input  wire [4:0] hold_i,
  output reg  [8:0] coil_o
);
  wire signed [8:0]  coil_s = coil_i;
  // Seven bits so that a hold setting of 31 gives +32 and not a negative factor
  wire        [6:0]  factor = {2'b00, hold_i} + 7'h01;
  wire signed [15:0] prod   = coil_s * $signed(factor);
  wire signed [15:0] shr    = prod >>> 5;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coil_o <= 9'h000;
    end else begin
      coil_o <= shr[8:0];
    end
  end
endmodule // gcs_coil_scale

// ==== gcs_global_regs_checker.sv ====
`timescale 1ns/1ps
module gcs_global_regs_checker (
  input wire        REF_CLK_I, RST_N_I, REG_WR_I, HALT_INPUT_PIN_I, SEQ_STOP_O,
  input wire        IRQ_ACTIVE_I, IRQ_DIAG_PIN_O, IRQ_DIAG_PIN_OE_O, COMPARE_ACTIVE_I,
  input wire        COMPARE_DIAG_PIN_OE_O, QUIET_REG_EN_I, QUIET_REG_EN_O,
  input wire        PUMP_UNDERVOLT_I, DRIVER_ENABLE_O, TEST_ANALOG_EN_O,
  input wire        COMPARE_DIAG_PIN_O, FREQ_ABOVE_O, FREQ_BELOW_O,
  input wire        DECODER_OUT_I, DECODER_OUT_PIN_O,
  input wire [2:0]  TEST_SIG_I,
  input wire [1:0]  TEST_SELECT_O,
  input wire [6:0]  REG_ADDR_I,
  input wire [31:0] REG_WDATA_I, FREQ_REF_I, FREQ_ACT_I,
  input wire [8:0]  SEQ_COIL_A_I, COIL_A_O
);
  reg [17:0] cfg_q;
  reg [4:0]  hold_q;
  wire [31:0] hys = cfg_q[14] ? (FREQ_REF_I >> 5) : (FREQ_REF_I >> 4);
  wire [1:0]  sel = (hold_q[1:0] == 2'h3) ? 2'h2 : hold_q[1:0];
  always @(posedge REF_CLK_I or negedge RST_N_I)
    if (!RST_N_I) hold_q <= 5'h00;
    else if (REG_WR_I && REG_ADDR_I == 7'h10) hold_q <= REG_WDATA_I[4:0];
  // Shadow config, updated on the same edge as the design's copy
  always @(posedge REF_CLK_I or negedge RST_N_I)
    if (!RST_N_I) cfg_q <= 18'h00000;
    else if (REG_WR_I && REG_ADDR_I == 7'h00) cfg_q <= REG_WDATA_I[17:0];
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_IRQ: assert property (IRQ_DIAG_PIN_O == (cfg_q[12] & IRQ_ACTIVE_I) &&
    IRQ_DIAG_PIN_OE_O == (cfg_q[12] | IRQ_ACTIVE_I)) else $error("irq pin drive");
  AST_CMP: assert property (COMPARE_DIAG_PIN_OE_O == (cfg_q[13] | COMPARE_ACTIVE_I))
    else $error("compare pin drive");
  AST_STOP: assert property (SEQ_STOP_O == (cfg_q[15] & HALT_INPUT_PIN_I))
    else $error("stop output");
  AST_PASS: assert property (!cfg_q[16] |-> COIL_A_O == SEQ_COIL_A_I)
    else $error("coil pass");
  AST_QUIET: assert property (QUIET_REG_EN_O == (QUIET_REG_EN_I & ~cfg_q[16]))
    else $error("quiet regulation");
  AST_TEST: assert property (TEST_ANALOG_EN_O == cfg_q[17])
    else $error("test enable");
  AST_CFG: assert property (REG_WR_I && REG_ADDR_I == 7'h00 |=>
    TEST_ANALOG_EN_O == $past(REG_WDATA_I[17])) else $error("config write");
  AST_UV: assert property (PUMP_UNDERVOLT_I |-> !DRIVER_ENABLE_O)
    else $error("driver not disabled");
  AST_CMP_PIN: assert property (COMPARE_DIAG_PIN_O == (cfg_q[13] & COMPARE_ACTIVE_I))
    else $error("compare pin level");
  AST_ABOVE: assert property (FREQ_ABOVE_O ==
    ({1'b0, FREQ_ACT_I} > {1'b0, FREQ_REF_I} + hys)) else $error("frequency above");
  AST_BELOW: assert property (FREQ_BELOW_O ==
    ({1'b0, FREQ_ACT_I} + hys < {1'b0, FREQ_REF_I})) else $error("frequency below");
  AST_DCO: assert property (TEST_SELECT_O == hold_q[1:0] &&
    DECODER_OUT_PIN_O == (cfg_q[17] ? TEST_SIG_I[sel] : DECODER_OUT_I))
    else $error("decoder pin routing");
endmodule // gcs_global_regs_checker
bind gcs_global_regs gcs_global_regs_checker chk (.*);

// ==== gcs_host_model.sv ====
`timescale 1ns/1ps
module gcs_host_model (
  input  wire        clk_i,
  output reg  [6:0]  addr_o = 7'h00,
  output reg         wr_o = 1'b0,
  output reg         rd_o = 1'b0,
  output reg  [31:0] wdata_o = 32'h0
);
  // Released bus shows inverted data after a write and inverted address after a read so stale values never pass
  task wr_reg(input [6:0] a, input [31:0] v);
    @(negedge clk_i);
    addr_o = a; wdata_o = v; wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0; wdata_o = ~v;
  endtask
  task rd_reg(input [6:0] a);
    @(negedge clk_i);
    addr_o = a; rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0; addr_o = ~a;
  endtask
endmodule // gcs_host_model

// ==== gcs_global_regs_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin failures++; \
  $display("unexpected %0t got %h want %h", $time, g, w); end end
module gcs_global_regs_tb_top;
  reg        clk = 0, rst_n = 0, uart = 0, ot = 0, uv = 0, rd_d = 0;
  reg [31:0] rnd = 32'he6fc9099, e;
  reg [47:0] rin = 0;
  wire [6:0] a;
  wire       w, r;
  wire [31:0] wd, rdat;
  wire [8:0] ca, cb;
  int        failures = 0, n_tests = 0, i;
  logic [31:0] exp_q[$];
  always #20 clk = ~clk;
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  gcs_host_model host (.clk_i(clk), .addr_o(a), .wr_o(w), .rd_o(r), .wdata_o(wd));
  gcs_global_regs uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(a), .REG_WR_I(w),
    .REG_WDATA_I(wd), .REG_RD_I(r), .REG_RDATA_O(rdat), .REG_UART_MODE_I(uart),
    .DRV_OVERTEMP_I(ot), .DRV_SHORT_I(rin[40]), .PUMP_UNDERVOLT_I(uv),
    .IRQ_ACTIVE_I(rin[1]), .COMPARE_ACTIVE_I(rin[2]), .HALT_INPUT_PIN_I(rin[0]),
    .FREQ_REF_I({16'h0, rin[23:8]}), .FREQ_ACT_I({16'h0, rin[39:24]}),
    .SEQ_COIL_A_I(rin[47:39]), .SEQ_COIL_B_I(rin[16:8]), .QUIET_REG_EN_I(rin[3]),
    .TEST_SIG_I(rin[7:5]), .DECODER_OUT_I(rin[4]), .IRQ_DIAG_PIN_O(),
    .IRQ_DIAG_PIN_OE_O(), .COMPARE_DIAG_PIN_O(), .COMPARE_DIAG_PIN_OE_O(),
    .FREQ_ABOVE_O(), .FREQ_BELOW_O(), .SEQ_STOP_O(), .COIL_A_O(ca), .COIL_B_O(cb),
    .QUIET_REG_EN_O(), .DRIVER_ENABLE_O(), .DECODER_OUT_PIN_O(),
    .TEST_ANALOG_EN_O(), .TEST_SELECT_O());
  task rd(input [6:0] ad, input [31:0] x);
    exp_q.push_back(x);
    host.rd_reg(ad);
  endtask
  task print_verdict;
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) rd_d <= r;
  always @(negedge clk) if (rd_d) begin
    e = exp_q.pop_front();
    `CHK(rdat, e)
  end
  initial begin
    #400000;
    failures++;
    print_verdict;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    rd(7'h01, 32'h1);
    rd(7'h01, 32'h0);
    rd(7'h02, 32'h0);
    rd(7'h00, 32'h0);
    rd(7'h55, 32'h0);
    host.wr_reg(7'h00, 32'h3f000);
    rd(7'h02, 32'h0);
    rd(7'h00, 32'h3f000);
    ot = 1;
    rd(7'h01, 32'h2);
    rd(7'h01, 32'h2);
    ot = 0;
    rd(7'h01, 32'h2);
    rd(7'h01, 32'h0);
    uv = 1;
    rd(7'h01, 32'h4);
    uv = 0;
    host.wr_reg(7'h2d, {7'h0, 9'h040, 7'h0, 9'h1c0});
    host.wr_reg(7'h10, 32'hf);
    host.wr_reg(7'h00, 32'h10000);
    repeat (3) @(negedge clk);
    `CHK(ca, 9'h1e0)
    `CHK(cb, 9'h020)
    host.wr_reg(7'h10, 32'h1f);
    repeat (3) @(negedge clk);
    `CHK(ca, 9'h1c0)
    uart = 1;
    // Random writes keep the test bit clear 257 writes wrap the count
    for (i = 0; i < 257; i++) begin
      rnd = lfsr(rnd);
      rin = {rnd[15:0], rnd};
      host.wr_reg(7'h00, rnd & 32'h1ffff);
    end
    rd(7'h00, rnd & 32'h1ffff);
    rd(7'h02, 32'h1);
    rd(7'h02, 32'h1);
    rin = 48'h0;
    @(negedge clk);
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    rd(7'h01, 32'h1);
    rd(7'h02, 32'h0);
    rd(7'h00, 32'h0);
    repeat (2) @(negedge clk);
    print_verdict;
  end
endmodule // gcs_global_regs_tb_top
